// *** rtl/ebt_defs.svh ***
// Function
// - enable drives output to initial level
// - enable outside demod loads low hold if level 0
// - single-pass counts down, stops, toggles, flags
// - modulo-N first terminal toggles, no interrupt
// - modulo-N reloads per level, flags each period after the first
// - hold writes apply only at next reload
// - initial count zero gives 256-step period
// - demod edges capture count high or low
// - capture sets edge flag, edge interrupt
// - capture reloads counter with all ones
// - demod zero sets timeout, keeps counting
`ifndef EBT_DEFS_SVH
`define EBT_DEFS_SVH

// ************************************************************
// register word indices, byte address is four times these
// ************************************************************
`define EBT_IDX_MODE     6'h00
`define EBT_IDX_SHARED   6'h01
`define EBT_IDX_LOW      6'h04
`define EBT_IDX_HIGH     6'h05
`define EBT_IDX_CAPLO    6'h0a
`define EBT_IDX_CAPHI    6'h0b
`define EBT_IDX_STAT     6'h10
`define EBT_IDX_MASK     6'h11
`define EBT_IDX_COUNT    6'h12

// ************************************************************
// field positions and values
// ************************************************************
`define EBT_SH_INIT      1
`define EBT_SH_NEG       1
`define EBT_SH_POS       0
`define EBT_RST_BYTE     8'h00
`define EBT_RST_STAT     3'h0
`define EBT_CNT_FULL     8'hff
`define EBT_CNT_ONE      8'h01
`define EBT_CNT_ZERO     8'h00
`define EBT_RESP_OKAY    2'h0
`define EBT_RESP_SLVERR  2'h2
`define EBT_PAD_W        24
`define EBT_PAD          24'h000000

`endif

// *** rtl/ebt_pkg.sv ***
`include "ebt_defs.svh"

package ebt_pkg;

   // ************************************************************
   // control layout and state codes
   // ************************************************************
   typedef struct packed {
      logic       en;
      logic       single;
      logic       to_view;
      logic [1:0] rsv;
      logic       edge_ie;
      logic       to_ie;
      logic       demod;
   } ebt_mode_t;

   typedef struct packed {
      logic pos_cap;
      logic neg_cap;
      logic timeout;
   } ebt_stat_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_XMIT  = 2'b01,
      ST_DEMOD = 2'b11
   } ebt_state_t;

endpackage : ebt_pkg

// *** rtl/ebt_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebt_defs.svh"

module ebt_timer
   import ebt_pkg::*;
(
   input  wire logic       clk_i,           // 200 MHz clock
   input  wire logic       rst_i,           // async reset, high
   input  wire logic       ce_i,            // clock enable
   input  wire logic [7:0] s_axi_awaddr_i,  // write address
   input  wire logic       s_axi_awvalid_i, // write address valid
   output logic            s_axi_awready_o, // write address ready
   input  wire logic [31:0] s_axi_wdata_i,  // write data
   input  wire logic [3:0] s_axi_wstrb_i,   // write strobes
   input  wire logic       s_axi_wvalid_i,  // write data valid
   output logic            s_axi_wready_o,  // write data ready
   output logic [1:0]      s_axi_bresp_o,   // write response
   output logic            s_axi_bvalid_o,  // write response valid
   input  wire logic       s_axi_bready_i,  // write response ready
   input  wire logic [7:0] s_axi_araddr_i,  // read address
   input  wire logic       s_axi_arvalid_i, // read address valid
   output logic            s_axi_arready_o, // read address ready
   output logic [31:0]     s_axi_rdata_o,   // read data
   output logic [1:0]      s_axi_rresp_o,   // read response
   output logic            s_axi_rvalid_o,  // read data valid
   input  wire logic       s_axi_rready_i,  // read data ready
   input  wire logic       demod_in_i,      // demodulation input pin
   output logic            timer_wave_output_o, // waveform pin
   output logic            irq_o            // level interrupt
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] ebt_sel_hold(input logic lvl,
                                               input logic [7:0] lo,
                                               input logic [7:0] hi);
      ebt_sel_hold = lvl ? hi : lo;
   endfunction : ebt_sel_hold

   function automatic logic ebt_mapped(input logic [5:0] idx);
      ebt_mapped = (idx == `EBT_IDX_MODE)  || (idx == `EBT_IDX_SHARED) ||
                   (idx == `EBT_IDX_LOW)   || (idx == `EBT_IDX_HIGH)   ||
                   (idx == `EBT_IDX_CAPLO) || (idx == `EBT_IDX_CAPHI)  ||
                   (idx == `EBT_IDX_STAT)  || (idx == `EBT_IDX_MASK)   ||
                   (idx == `EBT_IDX_COUNT);
   endfunction : ebt_mapped

   // ************************************************************
   // state
   // ************************************************************
   logic        aw_have_q;
   logic [5:0]  aw_idx_q;
   logic        w_have_q;
   logic [7:0]  w_byte_q;
   logic        w_lane_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   ebt_mode_t   mode_q;
   logic        init_q;
   logic [7:0]  low_hold_q;
   logic [7:0]  high_hold_q;
   logic [7:0]  cap_lo_q;
   logic [7:0]  cap_lo_d;
   logic [7:0]  cap_hi_q;
   logic [7:0]  cap_hi_d;
   ebt_stat_t   stat_q;
   ebt_stat_t   stat_d;
   ebt_stat_t   mask_q;
   logic [7:0]  cnt_q;
   logic [7:0]  cnt_d;
   logic        wave_q;
   logic        wave_d;
   logic        first_q;
   logic        first_d;
   ebt_state_t  st_q;
   ebt_state_t  st_d;
   logic        irq_q;
   logic [2:0]  pin_q;
   logic        pin_f_q;

   // ************************************************************
   // bus decode
   // ************************************************************
   wire        aw_take  = s_axi_awvalid_i & awready_q;
   wire        w_take   = s_axi_wvalid_i & wready_q;
   wire        do_wr    = aw_have_q & w_have_q & ~bvalid_q;
   wire        aw_have_d = aw_take | (aw_have_q & ~do_wr);
   wire        w_have_d = w_take | (w_have_q & ~do_wr);
   wire        bvalid_d = do_wr | (bvalid_q & ~s_axi_bready_i);
   wire        ar_take  = s_axi_arvalid_i & arready_q;
   wire        rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_i);
   wire        wr_en    = do_wr & w_lane_q;
   wire        wr_mode  = wr_en & (aw_idx_q == `EBT_IDX_MODE);
   wire        wr_shared = wr_en & (aw_idx_q == `EBT_IDX_SHARED);
   wire        wr_low   = wr_en & (aw_idx_q == `EBT_IDX_LOW);
   wire        wr_high  = wr_en & (aw_idx_q == `EBT_IDX_HIGH);
   wire        wr_stat  = wr_en & (aw_idx_q == `EBT_IDX_STAT);
   wire        wr_mask  = wr_en & (aw_idx_q == `EBT_IDX_MASK);
   ebt_mode_t  mode_w;
   assign mode_w = ebt_mode_t'(w_byte_q);
   wire        start_w  = wr_mode & mode_w.en & ~mode_q.en;
   wire        halt_w   = wr_mode & ~mode_w.en;
   wire [2:0]  clr_w    = wr_stat ? w_byte_q[2:0] : `EBT_RST_STAT;

   // ************************************************************
   // read mux
   // ************************************************************
   wire [5:0]  rd_idx   = s_axi_araddr_i[7:2];
   wire [7:0]  mode_rd  = {mode_q.en, mode_q.single, stat_q.timeout,
                           mode_q.rsv, mode_q.edge_ie, mode_q.to_ie,
                           mode_q.demod};
   // in demod the two low shared bits show the edge flags instead
   wire [7:0]  shared_rd = mode_q.demod ?
                           {6'h00, stat_q.neg_cap, stat_q.pos_cap} :
                           {6'h00, init_q, 1'b0};
   wire [7:0]  rd_byte  =
      (rd_idx == `EBT_IDX_MODE)   ? mode_rd :
      (rd_idx == `EBT_IDX_SHARED) ? shared_rd :
      (rd_idx == `EBT_IDX_LOW)    ? low_hold_q :
      (rd_idx == `EBT_IDX_HIGH)   ? high_hold_q :
      (rd_idx == `EBT_IDX_CAPLO)  ? cap_lo_q :
      (rd_idx == `EBT_IDX_CAPHI)  ? cap_hi_q :
      (rd_idx == `EBT_IDX_STAT)   ? {5'h00, stat_q} :
      (rd_idx == `EBT_IDX_MASK)   ? {5'h00, mask_q} :
      (rd_idx == `EBT_IDX_COUNT)  ? cnt_q : `EBT_RST_BYTE;
   wire [1:0]  rd_resp  = ebt_mapped(rd_idx) ? `EBT_RESP_OKAY :
                                               `EBT_RESP_SLVERR;

   // ************************************************************
   // pin filter: a change counts once stages two and three agree
   // ************************************************************
   wire        pin_stable = (pin_q[1] == pin_q[2]);
   wire        pin_neg  = pin_stable & pin_f_q & ~pin_q[2];
   wire        pin_pos  = pin_stable & ~pin_f_q & pin_q[2];

   // ************************************************************
   // counter engine
   // ************************************************************
   wire        term_w   = (cnt_q == `EBT_CNT_ONE);
   ebt_stat_t  set_w;

   always_comb
   begin
      cnt_d    = cnt_q;
      wave_d   = wave_q;
      first_d  = first_q;
      st_d     = st_q;
      cap_lo_d = cap_lo_q;
      cap_hi_d = cap_hi_q;
      set_w    = ebt_stat_t'(`EBT_RST_STAT);
      if (halt_w)
      begin
         st_d = ST_IDLE;
      end
      else if (start_w)
      begin
         wave_d  = init_q;
         first_d = 1'b1;
         if (mode_w.demod)
         begin
            st_d  = ST_DEMOD;
            cnt_d = `EBT_CNT_FULL;
         end
         else
         begin
            st_d  = ST_XMIT;
            cnt_d = ebt_sel_hold(init_q, low_hold_q,
                                 high_hold_q);
         end
      end
      else
      begin
         unique case (st_q)
            ST_IDLE:
            begin
               cnt_d = cnt_q;
            end
            ST_XMIT:
            begin
               // terminal is the step onto zero, so a count of zero
               // first wraps through all ones
               if (term_w)
               begin
                  wave_d = ~wave_q;
                  if (mode_q.single)
                  begin
                     cnt_d         = `EBT_CNT_ZERO;
                     st_d          = ST_IDLE;
                     set_w.timeout = 1'b1;
                  end
                  else
                  begin
                     // holds are sampled only here and at start
                     cnt_d = ebt_sel_hold(~wave_q, low_hold_q,
                                          high_hold_q);
                     first_d       = 1'b0;
                     set_w.timeout = ~first_q;
                  end
               end
               else
               begin
                  cnt_d = cnt_q - `EBT_CNT_ONE;
               end
            end
            ST_DEMOD:
            begin
               if (pin_neg)
               begin
                  cap_hi_d      = cnt_q;
                  set_w.neg_cap = 1'b1;
                  cnt_d         = `EBT_CNT_FULL;
               end
               else if (pin_pos)
               begin
                  cap_lo_d      = cnt_q;
                  set_w.pos_cap = 1'b1;
                  cnt_d         = `EBT_CNT_FULL;
               end
               else
               begin
                  // lands on zero, next step wraps to all ones
                  cnt_d         = cnt_q - `EBT_CNT_ONE;
                  set_w.timeout = term_w;
               end
            end
            default:
            begin
               st_d = ST_IDLE;
            end
         endcase
      end
   end

   // set beats a same-cycle clear so no event is lost
   assign stat_d = ebt_stat_t'((stat_q & ~clr_w) | set_w);
   wire [2:0] ie_w = {mode_q.edge_ie, mode_q.edge_ie, mode_q.to_ie};
   wire       irq_d = |(stat_d & mask_q & ie_w);

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aw_have_q <= 1'b0;
         aw_idx_q  <= 6'h00;
         w_have_q  <= 1'b0;
         w_byte_q  <= `EBT_RST_BYTE;
         w_lane_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `EBT_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `EBT_RESP_OKAY;
      end
      else if (ce_i)
      begin
         if (aw_take)
         begin
            aw_idx_q <= s_axi_awaddr_i[7:2];
         end
         if (w_take)
         begin
            w_byte_q <= s_axi_wdata_i[7:0];
            w_lane_q <= s_axi_wstrb_i[0];
         end
         if (do_wr)
         begin
            bresp_q <= ebt_mapped(aw_idx_q) ? `EBT_RESP_OKAY :
                                              `EBT_RESP_SLVERR;
         end
         if (ar_take)
         begin
            rdata_q <= {`EBT_PAD, rd_byte};
            rresp_q <= rd_resp;
         end
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         bvalid_q  <= bvalid_d;
         rvalid_q  <= rvalid_d;
         awready_q <= ~aw_have_d & ~bvalid_d;
         wready_q  <= ~w_have_d & ~bvalid_d;
         arready_q <= ~rvalid_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_q      <= ebt_mode_t'(`EBT_RST_BYTE);
         init_q      <= 1'b0;
         low_hold_q  <= `EBT_RST_BYTE;
         high_hold_q <= `EBT_RST_BYTE;
         mask_q      <= ebt_stat_t'(`EBT_RST_STAT);
      end
      else if (ce_i)
      begin
         if (wr_mode)
         begin
            mode_q         <= mode_w;
            mode_q.to_view <= 1'b0;
            mode_q.rsv     <= 2'b00;
         end
         if (wr_shared)
         begin
            init_q <= w_byte_q[`EBT_SH_INIT];
         end
         if (wr_low)
         begin
            low_hold_q <= w_byte_q;
         end
         if (wr_high)
         begin
            high_hold_q <= w_byte_q;
         end
         if (wr_mask)
         begin
            mask_q <= ebt_stat_t'(w_byte_q[2:0]);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q    <= `EBT_CNT_ZERO;
         wave_q   <= 1'b0;
         first_q  <= 1'b0;
         st_q     <= ST_IDLE;
         cap_lo_q <= `EBT_RST_BYTE;
         cap_hi_q <= `EBT_RST_BYTE;
         stat_q   <= ebt_stat_t'(`EBT_RST_STAT);
         irq_q    <= 1'b0;
         pin_q    <= 3'h0;
         pin_f_q  <= 1'b0;
      end
      else if (ce_i)
      begin
         cnt_q    <= cnt_d;
         wave_q   <= wave_d;
         first_q  <= first_d;
         st_q     <= st_d;
         cap_lo_q <= cap_lo_d;
         cap_hi_q <= cap_hi_d;
         stat_q   <= stat_d;
         irq_q    <= irq_d;
         pin_q    <= {pin_q[1:0], demod_in_i};
         if (pin_stable)
         begin
            pin_f_q <= pin_q[2];
         end
      end
   end

   assign s_axi_awready_o     = awready_q;
   assign s_axi_wready_o      = wready_q;
   assign s_axi_bvalid_o      = bvalid_q;
   assign s_axi_bresp_o       = bresp_q;
   assign s_axi_arready_o     = arready_q;
   assign s_axi_rvalid_o      = rvalid_q;
   assign s_axi_rdata_o       = rdata_q;
   assign s_axi_rresp_o       = rresp_q;
   assign timer_wave_output_o = wave_q;
   assign irq_o               = irq_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_START_LEVEL: assert property (
      ce_i && start_w |=> wave_q == $past(init_q) && first_q)
      else $error("output not at initial level after enable");

   AST_START_LOAD: assert property (
      ce_i && start_w && !mode_w.demod |=>
      cnt_q == ($past(init_q) ? $past(high_hold_q) : $past(low_hold_q)))
      else $error("wrong hold loaded on enable");

   AST_SINGLE_STOP: assert property (
      ce_i && !wr_mode && st_q == ST_XMIT && mode_q.single && term_w
      |=> st_q == ST_IDLE && cnt_q == `EBT_CNT_ZERO && stat_q.timeout
          && wave_q != $past(wave_q))
      else $error("single pass did not stop with timeout");

   AST_FIRST_SILENT: assert property (
      ce_i && !wr_mode && st_q == ST_XMIT && !mode_q.single && term_w
      && first_q |-> !set_w.timeout ##1 !first_q)
      else $error("first modulo terminal raised timeout");

   AST_MOD_RELOAD: assert property (
      ce_i && !wr_mode && st_q == ST_XMIT && !mode_q.single && term_w
      |=> wave_q != $past(wave_q) && cnt_q ==
          (wave_q ? $past(high_hold_q) : $past(low_hold_q)))
      else $error("modulo reload from wrong hold");

   AST_DECREMENT: assert property (
      ce_i && !wr_mode && st_q != ST_IDLE && !term_w && !pin_neg
      && !pin_pos |=> cnt_q == $past(cnt_q) - `EBT_CNT_ONE)
      else $error("counter did not step by one");

   AST_CAPTURE_HI: assert property (
      ce_i && !wr_mode && st_q == ST_DEMOD && pin_neg |=>
      cap_hi_q == $past(cnt_q) && cnt_q == `EBT_CNT_FULL
      && stat_q.neg_cap)
      else $error("negative edge capture failed");

   AST_CAPTURE_LO: assert property (
      ce_i && !wr_mode && st_q == ST_DEMOD && pin_pos |=>
      cap_lo_q == $past(cnt_q) && cnt_q == `EBT_CNT_FULL
      && stat_q.pos_cap)
      else $error("positive edge capture failed");

   AST_DEMOD_WRAP: assert property (
      ce_i && !wr_mode && st_q == ST_DEMOD && term_w && !pin_neg
      && !pin_pos ##1 ce_i && !wr_mode && !clr_w[0] && !pin_neg
      && !pin_pos |=> cnt_q == `EBT_CNT_FULL && stat_q.timeout)
      else $error("demod did not wrap after zero");

   AST_STICKY: assert property (
      stat_q.timeout && !(ce_i && clr_w[0]) |=> stat_q.timeout)
      else $error("timeout flag dropped without clear");

endmodule : ebt_timer

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebt_defs.svh"

module tb
   import ebt_pkg::*;
;
   // ************************************************************
   // register addresses and bench signals
   // ************************************************************
   localparam logic [7:0] A_MODE  = {`EBT_IDX_MODE, 2'b00};
   localparam logic [7:0] A_SHR   = {`EBT_IDX_SHARED, 2'b00};
   localparam logic [7:0] A_LOW   = {`EBT_IDX_LOW, 2'b00};
   localparam logic [7:0] A_HIGH  = {`EBT_IDX_HIGH, 2'b00};
   localparam logic [7:0] A_CAPLO = {`EBT_IDX_CAPLO, 2'b00};
   localparam logic [7:0] A_CAPHI = {`EBT_IDX_CAPHI, 2'b00};
   localparam logic [7:0] A_STAT  = {`EBT_IDX_STAT, 2'b00};
   localparam logic [7:0] A_MASK  = {`EBT_IDX_MASK, 2'b00};
   localparam logic [7:0] A_CNT   = {`EBT_IDX_COUNT, 2'b00};
   localparam logic [1:0] OK      = `EBT_RESP_OKAY;

   logic        clk, rst, ce, demod_in, wave, irq, wv_prev;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          n_mismatch, comparisons, cyc;
   int          q_t[$];

   ebt_timer ebt_timer_inst (
      .clk_i(clk), .rst_i(rst), .ce_i(ce),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .demod_in_i(demod_in),
      .timer_wave_output_o(wave), .irq_o(irq)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ************************************************************
   // wave edge log and hang guard
   // ************************************************************
   // toggle times sampled mid-cycle, away from the launching edge
   always @(negedge clk)
   begin
      cyc++;
      if (wave !== wv_prev) q_t.push_back(cyc);
      wv_prev = wave;
      if (cyc == 20000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   // ************************************************************
   // compare, bus and wait tasks
   // ************************************************************
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk_val(input logic [31:0] got, exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_val

   task automatic chk_resp(input logic [1:0] got, exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t %s resp %h exp %h", $time, m, got, exp);
      end
   endtask : chk_resp

   // valid held until the ready seen high at the sampling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      logic aw_t, w_t;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(negedge clk);
         aw_t = awvalid & awready;
         w_t  = wvalid & wready;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      while (awvalid | wvalid);
      do @(negedge clk); while (bvalid !== 1'b1);
      chk_resp(bresp, er, "write response");
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     input logic [1:0] er);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      v = rdata;
      chk_resp(rresp, er, "read response");
      @(posedge clk);
      rready <= 1'b0;
      // later pin checks must not race the edge just passed
      @(negedge clk);
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v, OK);
      chk_val(v, e, "register read");
   endtask : rd_chk

   task automatic wait_ev(input int n);
      while (q_t.size() < n) @(negedge clk);
   endtask : wait_ev

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      logic [7:0] adr[7] = '{A_MODE, A_SHR, A_LOW, A_HIGH, A_STAT,
                             A_MASK, A_CNT};
      foreach (adr[i]) rd_chk(adr[i], 32'h0);
      rd(8'hfc, d, `EBT_RESP_SLVERR);
      chk_val(d, 32'h0, "unmapped read");
      wr(8'hfc, 32'hff, `EBT_RESP_SLVERR);
      // low byte lane off: answered but ignored
      @(posedge clk);
      wstrb <= 4'he;
      wr(A_LOW, 32'h55, OK);
      wstrb <= 4'hf;
      rd_chk(A_LOW, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_single();
      wr(A_SHR, 32'h2, OK);
      wr(A_HIGH, 32'h0a, OK);
      wr(A_MASK, 32'h1, OK);
      wr(A_MODE, 32'hc2, OK);
      repeat (3) @(negedge clk);
      chk_val(32'(wave), 32'h1, "initial level");
      wait_ev(2);
      chk_val(32'(q_t[1] - q_t[0]), 32'd10, "high load");
      repeat (30) @(negedge clk);
      chk_val(32'(q_t.size()), 32'h2, "single toggle");
      chk_val(32'(irq), 32'h1, "timeout irq");
      rd_chk(A_STAT, 32'h1);
      rd_chk(A_MODE, 32'he2);
      rd_chk(A_CNT, 32'h0);
      wr(A_STAT, 32'h1, OK);
      repeat (2) @(negedge clk);
      chk_val(32'(irq), 32'h0, "irq cleared");
      rd_chk(A_STAT, 32'h0);
      wr(A_MODE, 32'h0, OK);
      $display("test single done");
   endtask : t_single

   task automatic t_modulo();
      wr(A_LOW, 32'd20, OK);
      wr(A_HIGH, 32'd30, OK);
      q_t.delete();
      wr(A_MODE, 32'h82, OK);
      wait_ev(2);
      chk_val(32'(q_t[1] - q_t[0]), 32'd30, "high first");
      rd_chk(A_STAT, 32'h0);
      chk_val(32'(irq), 32'h0, "no first irq");
      // written mid-period, well away from any reload
      wr(A_HIGH, 32'd12, OK);
      wait_ev(3);
      chk_val(32'(q_t[2] - q_t[1]), 32'd20, "low period");
      rd_chk(A_STAT, 32'h1);
      chk_val(32'(irq), 32'h1, "period irq");
      // frozen cycles must not count as ticks
      @(posedge clk);
      ce <= 1'b0;
      repeat (7) @(posedge clk);
      ce <= 1'b1;
      wait_ev(4);
      chk_val(32'(q_t[3] - q_t[2]), 32'd19, "new high");
      wr(A_STAT, 32'h1, OK);
      wr(A_MODE, 32'h0, OK);
      $display("test modulo done");
   endtask : t_modulo

   task automatic t_wrap();
      wr(A_SHR, 32'h0, OK);
      wr(A_LOW, 32'h0, OK);
      wr(A_HIGH, 32'h0, OK);
      q_t.delete();
      wr(A_MODE, 32'h80, OK);
      wait_ev(3);
      chk_val(32'(q_t[2] - q_t[1]), 32'd256, "zero count");
      rd_chk(A_STAT, 32'h1);
      wr(A_MODE, 32'h0, OK);
      // leftover timeout would spoil the demod status checks
      wr(A_STAT, 32'h1, OK);
      $display("test wrap done");
   endtask : t_wrap

   task automatic t_demod();
      wr(A_MASK, 32'h6, OK);
      wr(A_MODE, 32'h85, OK);
      repeat (40) @(posedge clk);
      demod_in <= 1'b0;
      repeat (10) @(negedge clk);
      rd(A_CAPHI, d, OK);
      // pin sync latency leaves the captured count a few steps loose
      chk_val(32'(d >= 32'hc8 && d <= 32'hd8), 32'h1, "cap high");
      rd(A_CNT, d, OK);
      chk_val(32'(d >= 32'he0), 32'h1, "reload");
      rd_chk(A_STAT, 32'h2);
      chk_val(32'(irq), 32'h1, "edge irq");
      rd_chk(A_SHR, 32'h2);
      wr(A_STAT, 32'h2, OK);
      repeat (2) @(negedge clk);
      chk_val(32'(irq), 32'h0, "edge cleared");
      @(posedge clk);
      demod_in <= 1'b1;
      repeat (10) @(negedge clk);
      rd_chk(A_STAT, 32'h4);
      rd(A_CAPLO, d, OK);
      chk_val(32'(d >= 32'hc8 && d <= 32'hf8), 32'h1, "cap low");
      wr(A_STAT, 32'h4, OK);
      repeat (270) @(negedge clk);
      rd_chk(A_STAT, 32'h1);
      chk_val(32'(irq), 32'h0, "masked timeout");
      $display("test demod done");
   endtask : t_demod

   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      demod_in = 1'b1;
      wv_prev = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_single();
      t_modulo();
      t_wrap();
      t_demod();
      close_out();
   end

endmodule : tb
`default_nettype wire
